/* File: buf_pair_track.sv */
`timescale 1ns/1ps
module buf_pair_track (
    input  wire logic                        clk,     // system clock
    input  wire logic                        srst,    // sync reset, high
    input  wire dma_status_pkg::buf_ctrl_type ctrl,   // load, done, dma reset
    output logic [1:0]                       loaded,  // [1] b, [0] a
    output logic [1:0]                       active   // buffer in use
);

    typedef struct packed {
        logic [1:0] loaded;
        logic       first_b;                // b was loaded before a
        logic [1:0] active;
    } pair_state_type;

    pair_state_type s_q;
    pair_state_type s_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (ctrl.done_a) begin
            s_d.loaded[0] = 1'b0;
        end
        if (ctrl.done_b) begin
            s_d.loaded[1] = 1'b0;
        end
        // a load of a buffer that is still busy is ignored
        if (ctrl.load_a && !s_q.loaded[0]) begin
            s_d.loaded[0] = 1'b1;
        end
        if (ctrl.load_b && !s_q.loaded[1]) begin
            s_d.loaded[1] = 1'b1;
        end
        if (ctrl.dma_reset) begin
            s_d.loaded = dma_status_pkg::PAIR_RST;
        end
        // with both loaded the earlier one stays in use, a if loaded together
        case (s_d.loaded)
            2'h1:    s_d.first_b = 1'b0;
            2'h2:    s_d.first_b = 1'b1;
            2'h3:    s_d.first_b = (s_q.loaded == 2'h2) || (s_q.loaded == 2'h3 && s_q.first_b);
            default: s_d.first_b = 1'b0;
        endcase
        case (s_d.loaded)
            2'h1:    s_d.active = 2'h1;
            2'h2:    s_d.active = 2'h2;
            2'h3:    s_d.active = s_d.first_b ? 2'h2 : 2'h1;
            default: s_d.active = dma_status_pkg::PAIR_RST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign loaded = s_q.loaded;
    assign active = s_q.active;

endmodule : buf_pair_track

/* File: dma_status_pkg.sv */
package dma_status_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [17:0] STATUS_IDX   = 18'h04496;
    localparam logic [17:0] IRQ_FLAG_IDX = 18'h044a0;
    localparam logic [17:0] IRQ_MASK_IDX = 18'h044a1;

    // ------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------
    localparam int RX_ACT_POS  = 0;
    localparam int TX_ACT_POS  = 2;
    localparam int OVR_POS     = 4;
    localparam int PAR_POS     = 6;
    localparam int FRM_POS     = 8;
    localparam int EVENT_POS   = 4;
    localparam int EVENT_W     = 6;
    localparam int STATUS_W    = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0]        STATUS_RST = 16'h0000;
    localparam logic [EVENT_W-1:0] EVENT_RST  = 6'h00;
    localparam logic [1:0]         PAIR_RST   = 2'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic load_a;
        logic load_b;
        logic done_a;
        logic done_b;
        logic dma_reset;
    } buf_ctrl_type;

    typedef struct packed {
        logic valid;                    // byte accepted into a receive buffer
        logic buf_b;                    // 1: buffer b, 0: buffer a
        logic frame_err;
        logic parity_err;
    } rx_byte_type;

    typedef struct packed {
        logic full;
        logic empty;
    } rx_fifo_level_type;

endpackage : dma_status_pkg

/* File: dma_status_props.sv */
`timescale 1ns/1ps
module dma_status_props #(
    parameter int ADDR_W = 20
) (
    input wire logic              clk,      // clock
    input wire logic              srst,     // reset
    input wire logic              psel,     // select
    input wire logic              penable,  // access
    input wire logic              pwrite,   // write
    input wire logic [ADDR_W-1:0] paddr,    // address
    input wire logic [31:0]       prdata,   // read data
    input wire logic              pready,   // ready
    input wire logic              pslverr,  // error
    input wire logic              irq       // interrupt
);
    localparam logic [ADDR_W-1:0] ST_ADDR = ADDR_W'(dma_status_pkg::STATUS_IDX * 4);

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable && $past(penable))
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    status_word_a: assert property (pready && paddr == ST_ADDR |-> !pslverr && prdata[31:16] == 16'h0)
        else $error("status access wrong");
    hold_data_a: assert property (!pready |-> $stable(prdata))
        else $error("read data moved");
    irq_reset_a: assert property ($fell(srst) |-> !irq && !pready && !pslverr && prdata == 32'h0)
        else $error("outputs not cleared after reset");
endmodule : dma_status_props

/* File: rx_fifo_model.sv */
`timescale 1ns/1ps
module rx_fifo_model (
    input  wire logic                        clk,      // clock
    input  wire logic                        srst,     // reset
    input  wire logic                        send,     // pass one byte
    input  wire logic                        to_b,     // target buffer b
    input  wire logic                        frm,      // frame error
    input  wire logic                        par,      // parity error
    input  wire logic                        fill,     // fifo becomes full
    input  wire logic                        drain,    // fifo drained
    output dma_status_pkg::rx_byte_type       rx_byte,  // byte to buffer
    output dma_status_pkg::rx_fifo_level_type rx_fifo   // fifo level
);
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_byte <= '0;
            rx_fifo <= 2'b01;
        end else begin
            // error bits toggle while no byte is passed
            rx_byte.valid      <= send;
            rx_byte.buf_b      <= send ? to_b : ~rx_byte.buf_b;
            rx_byte.frame_err  <= send ? frm : ~rx_byte.frame_err;
            rx_byte.parity_err <= send ? par : ~rx_byte.parity_err;
            if (fill)
                rx_fifo <= 2'b10;
            else if (drain)
                rx_fifo <= 2'b01;
        end
    end
endmodule : rx_fifo_model

/* File: serial_dma_status.sv */
// How it works
// - a byte with framing error sets its buffer's frame flag, bit 9 or 8
// - error flags clear on their own buffer's next load or receive DMA reset
// - overrun arises when no receive buffer is loaded and the FIFO fills
// - overrun goes to the next loaded buffer, flagged when it drains FIFO
// - overrun flag sets only on drain, clears like the other error flags
// - receive active flags bits 1 (b) and 0 (a) show buffer in use
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module serial_dma_status #(
    parameter int ADDR_W = 20
) (
    input  wire logic                              clk,      // system clock
    input  wire logic                              srst,     // sync reset, high
    input  wire logic                              psel,     // apb select
    input  wire logic                              penable,  // apb access phase
    input  wire logic                              pwrite,   // apb write
    input  wire logic [ADDR_W-1:0]                 paddr,    // apb byte address
    input  wire logic [31:0]                       pwdata,   // apb write data
    output logic      [31:0]                       prdata,   // apb read data
    output logic                                   pready,   // apb ready
    output logic                                   pslverr,  // apb error
    input  wire dma_status_pkg::buf_ctrl_type      rx_ctrl,  // rx load/done/reset
    input  wire dma_status_pkg::buf_ctrl_type      tx_ctrl,  // tx load/done/reset
    input  wire dma_status_pkg::rx_byte_type       rx_byte,  // byte into buffer
    input  wire dma_status_pkg::rx_fifo_level_type rx_fifo,  // lower fifo level
    output logic                                   irq       // interrupt, level
);

    typedef struct packed {
        logic [1:0]                         frame_err;
        logic [1:0]                         parity_err;
        logic [1:0]                         overrun;
        logic                               ovr_pend;
        logic                               ovr_tgt_valid;
        logic                               ovr_tgt_b;
        logic [dma_status_pkg::EVENT_W-1:0] irq_flag;
        logic [dma_status_pkg::EVENT_W-1:0] irq_mask;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
        logic                               irq;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;

    logic [1:0] rx_loaded;
    logic [1:0] rx_active;
    logic [1:0] tx_active;

    // ------------------------------------------------------------
    // buffer tracking
    // ------------------------------------------------------------
    buf_pair_track u_rx_pair (
        .clk    (clk),
        .srst   (srst),
        .ctrl   (rx_ctrl),
        .loaded (rx_loaded),
        .active (rx_active)
    );

    // transmit side only feeds the active flags
    buf_pair_track u_tx_pair (
        .clk    (clk),
        .srst   (srst),
        .ctrl   (tx_ctrl),
        .loaded (),
        .active (tx_active)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [17:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        reg_hit   = (addr == byte_addr);
    endfunction : reg_hit

    function automatic logic [1:0] buf_sel(input logic hit, input logic to_b);
        buf_sel = hit ? (to_b ? 2'h2 : 2'h1) : 2'h0;
    endfunction : buf_sel

    // sticky per-buffer flag
    function automatic logic [1:0] sticky_next(input logic [1:0] cur,
                                               input logic [1:0] clr_b,
                                               input logic [1:0] set_b);
        sticky_next = (cur & ~clr_b) | set_b;
    endfunction : sticky_next

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    logic [15:0] status_word;

    always_comb begin
        status_word = dma_status_pkg::STATUS_RST;
        status_word[dma_status_pkg::RX_ACT_POS +: 2] = rx_active;
        status_word[dma_status_pkg::TX_ACT_POS +: 2] = tx_active;
        status_word[dma_status_pkg::OVR_POS +: 2]    = s_q.overrun;
        status_word[dma_status_pkg::PAR_POS +: 2]    = s_q.parity_err;
        status_word[dma_status_pkg::FRM_POS +: 2]    = s_q.frame_err;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [1:0]                         clr;
    logic [1:0]                         set_frm;
    logic [1:0]                         set_par;
    logic [1:0]                         set_ovr;
    logic [dma_status_pkg::EVENT_W-1:0] events;
    logic [dma_status_pkg::EVENT_W-1:0] w1c;
    logic                               access;
    logic                               hit_stat;
    logic                               hit_flag;
    logic                               hit_mask;

    always_comb begin
        s_d      = s_q;
        access   = psel && penable;
        hit_stat = reg_hit(paddr, dma_status_pkg::STATUS_IDX);
        hit_flag = reg_hit(paddr, dma_status_pkg::IRQ_FLAG_IDX);
        hit_mask = reg_hit(paddr, dma_status_pkg::IRQ_MASK_IDX);
        w1c      = '0;

        // load event or receive dma reset clears the flags
        clr = {rx_ctrl.load_b, rx_ctrl.load_a};
        if (rx_ctrl.dma_reset) begin
            clr = 2'h3;
        end

        set_frm = buf_sel(rx_byte.valid && rx_byte.frame_err, rx_byte.buf_b);
        set_par = buf_sel(rx_byte.valid && rx_byte.parity_err, rx_byte.buf_b);

        // overrun: no buffer loaded and the fifo fills
        if (rx_fifo.full && rx_loaded == 2'h0) begin
            s_d.ovr_pend = 1'b1;
        end
        // first load after the fill takes the overrun, a if both
        if (s_q.ovr_pend && !s_q.ovr_tgt_valid && (rx_ctrl.load_a || rx_ctrl.load_b)) begin
            s_d.ovr_tgt_valid = 1'b1;
            s_d.ovr_tgt_b     = !rx_ctrl.load_a;
        end
        // drained: fifo empty while the target buffer is still loaded
        set_ovr = '0;
        if (s_q.ovr_tgt_valid && rx_fifo.empty
            && rx_loaded[s_q.ovr_tgt_b ? 1 : 0]) begin
            set_ovr           = buf_sel(1'b1, s_q.ovr_tgt_b);
            s_d.ovr_pend      = 1'b0;
            s_d.ovr_tgt_valid = 1'b0;
        end
        if (rx_ctrl.dma_reset) begin
            s_d.ovr_pend      = 1'b0;
            s_d.ovr_tgt_valid = 1'b0;
        end

        // a set in the same cycle as a clear wins
        s_d.frame_err  = sticky_next(s_q.frame_err, clr, set_frm);
        s_d.parity_err = sticky_next(s_q.parity_err, clr, set_par);
        s_d.overrun    = sticky_next(s_q.overrun, clr, set_ovr);

        events = {set_frm & ~s_q.frame_err, set_par & ~s_q.parity_err,
                  set_ovr & ~s_q.overrun};

        // apb: one wait state, write takes effect with pready high
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (access && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !(hit_stat || hit_flag || hit_mask);
            s_d.prdata  = '0;
            if (!pwrite) begin
                if (hit_stat) begin
                    s_d.prdata[dma_status_pkg::STATUS_W-1:0] = status_word;
                end
                if (hit_flag) begin
                    s_d.prdata[dma_status_pkg::EVENT_POS +: dma_status_pkg::EVENT_W] = s_q.irq_flag;
                end
                if (hit_mask) begin
                    s_d.prdata[dma_status_pkg::EVENT_POS +: dma_status_pkg::EVENT_W] = s_q.irq_mask;
                end
            end
        end
        if (access && s_q.pready && pwrite) begin
            if (hit_flag) begin
                w1c = pwdata[dma_status_pkg::EVENT_POS +: dma_status_pkg::EVENT_W];
            end
            if (hit_mask) begin
                s_d.irq_mask = pwdata[dma_status_pkg::EVENT_POS +: dma_status_pkg::EVENT_W];
            end
        end

        s_d.irq_flag = (s_q.irq_flag & ~w1c) | events;
        s_d.irq      = |(s_d.irq_flag & s_d.irq_mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q          <= '0;
            s_q.irq_flag <= dma_status_pkg::EVENT_RST;
            s_q.irq_mask <= dma_status_pkg::EVENT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq     = s_q.irq;

endmodule : serial_dma_status

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic [19:0] A_ST = 20'(dma_status_pkg::STATUS_IDX * 4);
    localparam logic [19:0] A_FL = 20'(dma_status_pkg::IRQ_FLAG_IDX * 4);
    localparam logic [19:0] A_MK = 20'(dma_status_pkg::IRQ_MASK_IDX * 4);
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        send = 1'b0, to_b = 1'b0, frm = 1'b0, par = 1'b0, fill = 1'b0, drain = 1'b0;
    logic        pready, pslverr, irq, err;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          n_mismatch = 0, cmp_count = 0;
    dma_status_pkg::buf_ctrl_type      rx_ctrl = '0, tx_ctrl = '0;
    dma_status_pkg::rx_byte_type       rx_byte;
    dma_status_pkg::rx_fifo_level_type rx_fifo;

    always #20 clk = ~clk;

    serial_dma_status #(.ADDR_W(20)) dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_ctrl(rx_ctrl), .tx_ctrl(tx_ctrl),
        .rx_byte(rx_byte), .rx_fifo(rx_fifo), .irq(irq));
    rx_fifo_model fifo (.clk(clk), .srst(srst), .send(send), .to_b(to_b), .frm(frm),
        .par(par), .fill(fill), .drain(drain), .rx_byte(rx_byte), .rx_fifo(rx_fifo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [4:0] r, input logic [4:0] t);
        @(posedge clk);
        {rx_ctrl, tx_ctrl} <= {r, t};
        @(posedge clk);
        {rx_ctrl, tx_ctrl} <= 10'h0;
    endtask : pulse

    task automatic put(input logic b, input logic f, input logic p);
        @(posedge clk);
        {send, to_b, frm, par} <= {1'b1, b, f, p};
        @(posedge clk);
        send <= 1'b0;
    endtask : put

    task automatic t_reset;
        apb(1'b1, A_ST, 32'hffff);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_MK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_FL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 20'h00010, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset

    task automatic t_errs;
        apb(1'b1, A_MK, 32'h3f0);
        pulse(5'h18, 5'h08);
        put(1'b0, 1'b1, 1'b0);
        put(1'b1, 1'b0, 1'b1);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h189);
        chk({31'h0, irq}, 32'h1);
        pulse(5'h10, 5'h00);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h089);
        apb(1'b1, A_FL, 32'h3f0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pulse(5'h01, 5'h02);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h0);
    endtask : t_errs

    task automatic t_ovr;
        apb(1'b1, A_MK, 32'h020);
        @(posedge clk) fill <= 1'b1;
        @(posedge clk) fill <= 1'b0;
        pulse(5'h08, 5'h00);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h002);
        @(posedge clk) drain <= 1'b1;
        @(posedge clk) drain <= 1'b0;
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h022);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_MK, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pulse(5'h08, 5'h00);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h002);
    endtask : t_ovr

    task automatic t_order;
        pulse(5'h10, 5'h10);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h006);
        pulse(5'h02, 5'h08);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h005);
        pulse(5'h08, 5'h04);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h009);
        pulse(5'h06, 5'h01);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h0);
    endtask : t_order

    task automatic t_midrst;
        apb(1'b1, A_FL, 32'h3f0);
        apb(1'b1, A_MK, 32'h3f0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pulse(5'h10, 5'h00);
        put(1'b0, 1'b1, 1'b1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, A_FL, 32'h0);
        chk(rd, 32'h140);
        @(posedge clk) srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_FL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_MK, 32'h0);
        chk(rd, 32'h0);
    endtask : t_midrst

    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_errs;
        t_ovr;
        t_order;
        t_midrst;
        final_report;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
endmodule : tb_top

bind serial_dma_status dma_status_props #(.ADDR_W(ADDR_W)) props (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
